//--- rtl/cpm_pkg.sv
// shared constants, types and helper functions for the counter and pulse measurement unit
package cpm_pkg;

  // counter bank geometry
  localparam int          NUM_CTR       = 5;
  localparam int          CNT_W         = 16;
  localparam int          ADDR_W        = 12;
  localparam logic [15:0] CNT_MAX       = 16'hffff;

  // core clock
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          CLK_PERIOD_NS = 100;

  // internal timebases: divisors of the core clock, finest first
  localparam int          TB_NUM        = 4;
  localparam logic [31:0] TB_DIV0       = 32'h0000_0001;
  localparam logic [31:0] TB_DIV1       = 32'h0000_000a;
  localparam logic [31:0] TB_DIV2       = 32'h0000_0064;
  localparam logic [31:0] TB_DIV3       = 32'h0000_03e8;
  localparam logic [3:0]  TB_LAST_DIGIT = 4'h9;

  // least count a width or period result needs to be trusted
  localparam logic [15:0] MIN_VALID_CNT = 16'h0004;

  // register map: per-counter block, then global registers
  localparam logic [11:0] CH_STRIDE     = 12'h010;
  localparam logic [1:0]  REG_CTRL      = 2'h0;
  localparam logic [1:0]  REG_DELAY     = 2'h1;
  localparam logic [1:0]  REG_WIDTH     = 2'h2;
  localparam logic [1:0]  REG_COUNT     = 2'h3;
  localparam logic [11:0] OFF_CMD       = 12'h100;
  localparam logic [11:0] OFF_STATUS    = 12'h104;
  localparam int          CMD_START_LSB = 0;
  localparam int          CMD_STOP_LSB  = 8;
  localparam int          STAT_NIB      = 4;
  localparam int          CTRL_W        = 11;
  localparam logic [31:0] RST_VAL       = 32'h0000_0000;

  // counter modes in the mode field of the control register
  localparam logic [2:0]  MODE_EVENT    = 3'h0;
  localparam logic [2:0]  MODE_TIME     = 3'h1;
  localparam logic [2:0]  MODE_PULSE    = 3'h2;
  localparam logic [2:0]  MODE_TRAIN    = 3'h3;
  localparam logic [2:0]  MODE_WIDTH    = 3'h4;
  localparam logic [2:0]  MODE_PERIOD   = 3'h5;

  // gate handling
  localparam logic [1:0]  GATE_NONE     = 2'h0;
  localparam logic [1:0]  GATE_LEVEL    = 2'h1;
  localparam logic [1:0]  GATE_TRIG     = 2'h2;

  typedef struct packed {
    logic       chain;
    logic       pol_low;
    logic [1:0] gate;
    logic       edge_fall;
    logic [1:0] tb_idx;
    logic       clk_ext;
    logic [2:0] mode;
  } cpm_cfg_s;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ARMED,
    PH_DELAY,
    PH_PULSE,
    PH_COUNT,
    PH_MEAS
  } cpm_phase_e;

  typedef struct packed {
    cpm_phase_e       phase;
    logic [CNT_W-1:0] count;
    logic             out;
    logic             ovf;
    logic             done;
    logic             wrap;
    logic [1:0]       tb_sel;
  } cpm_ch_s;

  typedef struct packed {
    logic [3:0] c1;
    logic [3:0] c2;
    logic [3:0] c3;
    logic [3:0] tick;
  } cpm_tb_s;

  // divide a core-cycle figure down to cycles of one timebase
  function automatic logic [31:0] cnt_div(input logic [31:0] v, input logic [1:0] idx);
    logic [31:0] q;
    q = v;
    unique case (idx)
      2'h0: q = v / TB_DIV0;
      2'h1: q = v / TB_DIV1;
      2'h2: q = v / TB_DIV2;
      2'h3: q = v / TB_DIV3;
    endcase
    return q;
  endfunction

  // phase count from a programmed figure, held between one and full scale
  function automatic logic [CNT_W-1:0] cnt_load(input logic [31:0] v, input logic [1:0] idx,
                                                input logic ext);
    logic [31:0] q;
    q = ext ? v : cnt_div(v, idx);
    if (q == 32'h0) q = 32'h1;
    if (q > 32'h0000_ffff) q = 32'h0000_ffff;
    return q[CNT_W-1:0];
  endfunction

  // finest timebase that still holds both delay and width in one counter
  function automatic logic [1:0] tb_pick(input logic [31:0] dly, input logic [31:0] wid);
    logic [1:0] sel;
    sel = 2'h3;
    for (int k = TB_NUM - 1; k >= 0; k--) begin
      if (cnt_div(dly, 2'(k)) <= 32'h0000_ffff && cnt_div(wid, 2'(k)) <= 32'h0000_ffff) begin
        sel = 2'(k);
      end
    end
    return sel;
  endfunction

  // merge write data under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

endpackage

//--- rtl/cpm_timebase.sv
// internal timebase divider: one-cycle enables at the core rate and three decades below
`timescale 1ns/1ps
module cpm_timebase
  import cpm_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  output logic [TB_NUM-1:0]      tb_tick
);

  cpm_tb_s s_r;
  cpm_tb_s s_nxt;

  // cascaded decade counters; each carry feeds the next decade
  always_comb begin
    logic w1;
    logic w2;
    logic w3;
    s_nxt = s_r;
    w1 = (s_r.c1 == TB_LAST_DIGIT);
    w2 = w1 && (s_r.c2 == TB_LAST_DIGIT);
    w3 = w2 && (s_r.c3 == TB_LAST_DIGIT);
    s_nxt.c1 = w1 ? 4'h0 : s_r.c1 + 4'h1;
    if (w1) s_nxt.c2 = (s_r.c2 == TB_LAST_DIGIT) ? 4'h0 : s_r.c2 + 4'h1;
    if (w2) s_nxt.c3 = (s_r.c3 == TB_LAST_DIGIT) ? 4'h0 : s_r.c3 + 4'h1;
    s_nxt.tick = {w3, w2, w1, 1'b1};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tb_tick = s_r.tick;

endmodule

//--- rtl/cpm_edge.sv
// edge detector for a group of pin inputs
`timescale 1ns/1ps
module cpm_edge #(
  parameter int W = 5
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] sig,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  always_comb begin
    prev_nxt = sig;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // edges against last cycle's level
  assign rise = sig & ~prev_r;
  assign fall = ~sig & prev_r;

endmodule

//--- rtl/cpm_top.sv
// counter and pulse measurement unit: counter bank, pulse engines and apb register file
// Behaviour
// [R01] event mode counts chosen source edges; time mode counts timebase cycles
// [R02] single pulse: delay phase, pulse phase, then back to delay level
// [R03] external timebase: delay and width are counted in source clock cycles
// [R04] internal timebase: finest divisor that fits both delay and width is picked
// [R05] pulse generation may be gated by level or triggered by gate edge
// [R06] pulse train loops delay count then pulse count, over and over
// [R07] delay phase drives inactive level, pulse phase the polarity's active level
// [R08] finite train: lower counter makes a short gate pulse, wired externally
// [R09] train stops on stop command or when reprogrammed to single pulse
// [R10] frequency: counter counts rising source edges while gated by lower counter
// [R11] software starts event then gate counter, polls, reads, divides, stops
// [R12] width or period: gate signal bounds counting of internal timebase cycles
// [R13] software trusts results of at least four counts with no overflow
// [R14] width measurement must be armed before the measured phase begins
// [R15] five 16-bit counters with wrap-around adjacency between neighbours
// [R16] count read returns one counter or two chained counters concatenated
// [R17] repeated start reruns the same configured pulse without reprogramming
// [R18] phase count reloads at each boundary; output switches when count ends
`timescale 1ns/1ps
module cpm_top
  import cpm_pkg::*;
#(
  parameter int N = NUM_CTR
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N-1:0]      ctr_src,
  input  wire logic [N-1:0]      ctr_gate,
  output logic      [N-1:0]      ctr_out
);

  typedef struct packed {
    cpm_ch_s  [N-1:0]        ch;
    cpm_cfg_s [N-1:0]        cfg;
    logic     [N-1:0][31:0]  dly;
    logic     [N-1:0][31:0]  wid;
    logic     [31:0]         prdata;
    logic                    pready;
    logic                    pslverr;
  } cpm_top_s;

  cpm_top_s            s_r;
  cpm_top_s            s_nxt;

  logic [TB_NUM-1:0]   tb_tick;
  logic [N-1:0]        src_rise;
  logic [N-1:0]        src_fall;
  logic [N-1:0]        gate_rise;
  logic [N-1:0]        gate_fall;

  // decoded bus access, valid in the first access-phase cycle, one cycle before pready
  logic                acc;
  logic                in_ch;
  logic [3:0]          ch_sel;
  logic [1:0]          reg_sel;
  logic [N-1:0]        start_mask;
  logic [N-1:0]        stop_mask;
  logic [31:0]         rd_word;
  logic                rd_err;

  // per-channel scratch for the counter engine
  logic [N-1:0]        tick;
  logic [N-1:0]        gate_ok;
  logic [N-1:0]        meas_open;
  logic [N-1:0]        meas_close;

  cpm_timebase u_timebase (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tb_tick  (tb_tick)
  );

  cpm_edge #(.W(N)) u_src_edge (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sig      (ctr_src),
    .rise     (src_rise),
    .fall     (src_fall)
  );

  cpm_edge #(.W(N)) u_gate_edge (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sig      (ctr_gate),
    .rise     (gate_rise),
    .fall     (gate_fall)
  );

  // neighbour numbering wraps around the bank
  function automatic int nb_lo(input int i);
    return (i == 0) ? N - 1 : i - 1;
  endfunction

  function automatic int nb_hi(input int i);
    return (i == N - 1) ? 0 : i + 1;
  endfunction

  // apb decode; one wait state so reads come from a register
  always_comb begin
    acc     = psel && penable && !s_r.pready;
    in_ch   = (paddr < 12'(N * CH_STRIDE)) && (paddr[1:0] == 2'h0);
    ch_sel  = paddr[7:4];
    reg_sel = paddr[3:2];
    start_mask = '0;
    stop_mask  = '0;
    if (acc && pwrite && paddr == OFF_CMD) begin
      start_mask = pwdata[CMD_START_LSB +: N];
      stop_mask  = pwdata[CMD_STOP_LSB +: N];
    end
  end

  // read mux: counts, chained counts and status nibbles
  always_comb begin
    int hi;
    hi      = 0;
    rd_word = RST_VAL;
    rd_err  = 1'b0;
    if (in_ch) begin
      hi = nb_hi(int'(ch_sel));
      unique case (reg_sel)
        REG_CTRL:  rd_word = 32'(s_r.cfg[ch_sel]);
        REG_DELAY: rd_word = s_r.dly[ch_sel];
        REG_WIDTH: rd_word = s_r.wid[ch_sel];
        REG_COUNT: begin
          if (s_r.cfg[ch_sel].chain) begin
            rd_word = {s_r.ch[hi].count, s_r.ch[ch_sel].count}; // [R16]
          end else begin
            rd_word = {16'h0000, s_r.ch[ch_sel].count}; // [R16]
          end
        end
      endcase
    end else if (paddr == OFF_CMD) begin
      rd_word = RST_VAL;
    end else if (paddr == OFF_STATUS) begin
      for (int i = 0; i < N; i++) begin
        rd_word[i*STAT_NIB +: STAT_NIB] = {s_r.ch[i].done, s_r.ch[i].ovf, s_r.ch[i].out,
                                           s_r.ch[i].phase != PH_IDLE};
      end
    end else begin
      rd_err = 1'b1;
    end
  end

  // tick and gate qualification for each counter
  always_comb begin
    int lo;
    logic itk;
    lo  = 0;
    itk = 1'b0;
    for (int i = 0; i < N; i++) begin
      lo  = nb_lo(i);
      itk = 1'b0;
      unique case (s_r.cfg[i].mode)
        MODE_EVENT: itk = s_r.cfg[i].edge_fall ? src_fall[i] : src_rise[i]; // [R01] [R10]
        MODE_TIME:  itk = tb_tick[s_r.cfg[i].tb_idx]; // [R01]
        MODE_PULSE, MODE_TRAIN: begin
          // external clock counts its own cycles, internal uses the picked timebase
          itk = s_r.cfg[i].clk_ext ? src_rise[i] : tb_tick[s_r.ch[i].tb_sel]; // [R03]
        end
        MODE_WIDTH, MODE_PERIOD: itk = tb_tick[s_r.cfg[i].tb_idx]; // [R12]
        default: itk = 1'b0;
      endcase
      // the upper neighbour of a chained pair counts the lower one's wraps
      if (s_r.cfg[lo].chain && lo != i) begin
        itk = s_r.ch[lo].wrap; // [R10] [R15]
      end
      tick[i]    = itk;
      gate_ok[i] = (s_r.cfg[i].gate == GATE_LEVEL) ? ctr_gate[i] : 1'b1; // [R05] [R10]
      // measurement opens on the chosen gate edge
      meas_open[i] = s_r.cfg[i].edge_fall ? gate_fall[i] : gate_rise[i]; // [R12]
      if (s_r.cfg[i].mode == MODE_WIDTH) begin
        meas_close[i] = s_r.cfg[i].edge_fall ? gate_rise[i] : gate_fall[i]; // [R12]
      end else begin
        meas_close[i] = meas_open[i]; // [R12]
      end
    end
  end

  // register file and counter engines
  always_comb begin
    logic [1:0] pick;
    logic       inact;
    pick  = 2'h0;
    inact = 1'b0;
    s_nxt = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;

    // bus access completes one cycle after the access phase opens
    if (acc) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = rd_err;
      s_nxt.prdata  = pwrite ? RST_VAL : rd_word;
      if (pwrite && in_ch) begin
        unique case (reg_sel)
          REG_CTRL: begin
            // a live mode change is seen by a running train at its next pulse end
            s_nxt.cfg[ch_sel] = cpm_cfg_s'(CTRL_W'(strb_merge(32'(s_r.cfg[ch_sel]), pwdata,
                                                              pstrb)));
          end
          REG_DELAY: s_nxt.dly[ch_sel] = strb_merge(s_r.dly[ch_sel], pwdata, pstrb);
          REG_WIDTH: s_nxt.wid[ch_sel] = strb_merge(s_r.wid[ch_sel], pwdata, pstrb);
          REG_COUNT: s_nxt.dly[ch_sel] = s_r.dly[ch_sel];
        endcase
      end
    end

    for (int i = 0; i < N; i++) begin
      inact = s_r.cfg[i].pol_low; // [R07]
      pick  = tb_pick(s_r.dly[i], s_r.wid[i]); // [R04]
      s_nxt.ch[i].wrap = 1'b0;

      if (stop_mask[i]) begin
        // stop wins over a start in the same write
        s_nxt.ch[i].phase = PH_IDLE; // [R09]
        s_nxt.ch[i].out   = inact; // [R07]
      end else if (start_mask[i]) begin
        // every start reloads from the stored setup, so pulses repeat exactly
        s_nxt.ch[i].done = 1'b0; // [R17]
        s_nxt.ch[i].ovf  = 1'b0;
        s_nxt.ch[i].out  = inact; // [R07]
        unique case (s_r.cfg[i].mode)
          MODE_PULSE, MODE_TRAIN: begin
            s_nxt.ch[i].tb_sel = pick; // [R04]
            s_nxt.ch[i].count  = cnt_load(s_r.dly[i], pick, s_r.cfg[i].clk_ext); // [R17] [R03]
            s_nxt.ch[i].phase  = (s_r.cfg[i].gate == GATE_TRIG) ? PH_ARMED : PH_DELAY; // [R05]
          end
          MODE_WIDTH, MODE_PERIOD: begin
            s_nxt.ch[i].count = '0;
            s_nxt.ch[i].phase = PH_ARMED; // [R14]
          end
          default: begin
            s_nxt.ch[i].count = '0;
            s_nxt.ch[i].phase = (s_r.cfg[i].gate == GATE_TRIG) ? PH_ARMED : PH_COUNT; // [R05]
          end
        endcase
      end else begin
        unique case (s_r.ch[i].phase)
          PH_IDLE: begin
            s_nxt.ch[i].out = inact;
          end
          PH_ARMED: begin
            // pulse and counting modes wait for a gate edge, measurements for their edge
            if (s_r.cfg[i].mode == MODE_WIDTH || s_r.cfg[i].mode == MODE_PERIOD) begin
              if (meas_open[i]) s_nxt.ch[i].phase = PH_MEAS; // [R12]
            end else if (gate_rise[i]) begin
              s_nxt.ch[i].phase = (s_r.cfg[i].mode == MODE_PULSE ||
                                   s_r.cfg[i].mode == MODE_TRAIN) ? PH_DELAY : PH_COUNT; // [R05]
            end
          end
          PH_DELAY: begin
            if (tick[i] && gate_ok[i]) begin
              if (s_r.ch[i].count <= 16'h0001) begin
                s_nxt.ch[i].phase = PH_PULSE; // [R02] [R06]
                s_nxt.ch[i].count = cnt_load(s_r.wid[i], s_r.ch[i].tb_sel,
                                             s_r.cfg[i].clk_ext); // [R18] [R03]
                s_nxt.ch[i].out   = ~inact; // [R07] [R18]
              end else begin
                s_nxt.ch[i].count = s_r.ch[i].count - 16'h0001; // [R06]
              end
            end
          end
          PH_PULSE: begin
            if (tick[i] && gate_ok[i]) begin
              if (s_r.ch[i].count <= 16'h0001) begin
                s_nxt.ch[i].out = inact; // [R02] [R18]
                if (s_r.cfg[i].mode == MODE_TRAIN) begin
                  s_nxt.ch[i].phase = PH_DELAY; // [R06]
                  s_nxt.ch[i].count = cnt_load(s_r.dly[i], s_r.ch[i].tb_sel,
                                               s_r.cfg[i].clk_ext); // [R18]
                end else begin
                  // a train reprogrammed to single pulse ends here as well
                  s_nxt.ch[i].phase = PH_IDLE; // [R09] [R02] [R08]
                  s_nxt.ch[i].done  = 1'b1;
                end
              end else begin
                s_nxt.ch[i].count = s_r.ch[i].count - 16'h0001; // [R06]
              end
            end
          end
          PH_COUNT: begin
            // free counting wraps; the wrap feeds a chained upper neighbour
            if (tick[i] && gate_ok[i]) begin
              s_nxt.ch[i].count = s_r.ch[i].count + 16'h0001; // [R01] [R10]
              if (s_r.ch[i].count == CNT_MAX) begin
                s_nxt.ch[i].wrap = 1'b1; // [R16]
                if (!s_r.cfg[i].chain) s_nxt.ch[i].ovf = 1'b1;
              end
            end
          end
          PH_MEAS: begin
            if (meas_close[i]) begin
              s_nxt.ch[i].phase = PH_IDLE; // [R12]
              s_nxt.ch[i].done  = 1'b1;
            end else if (tick[i]) begin
              // saturate so an overflowed result cannot pass as a small one
              if (s_r.ch[i].count == CNT_MAX) begin
                s_nxt.ch[i].ovf = 1'b1;
              end else begin
                s_nxt.ch[i].count = s_r.ch[i].count + 16'h0001; // [R12]
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  always_comb begin
    prdata  = s_r.prdata;
    pready  = s_r.pready;
    pslverr = s_r.pslverr;
    for (int i = 0; i < N; i++) begin
      ctr_out[i] = s_r.ch[i].out;
    end
  end

endmodule

//--- sim/cpm_properties.sv
// apb timing and pin checks for the counter unit
`timescale 1ns/1ps
module cpm_properties
  import cpm_pkg::*;
#(
  parameter int N = NUM_CTR
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [N-1:0]      ctr_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_READY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  AST_ERR_PAIR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_WR_DATA: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  AST_UNALIGNED: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned accepted");
  AST_MAPPED: assert property (pready && paddr < 12'h050 && !paddr[1:0] |-> !pslverr)
    else $error("counter register refused");
  AST_CMD_READ: assert property (pready && !pwrite && paddr == OFF_CMD |-> prdata == 32'h0)
    else $error("command reads nonzero");
  AST_OUT_IDLE: assert property ($rose(rst_n) |-> ctr_out == '0 [*2])
    else $error("output active after reset");
  cover property (pready && pslverr);
  cover property ($rose(ctr_out[0]));
  cover property ($rose(ctr_out[1]) ##[1:20] $rose(ctr_out[1]));
endmodule

bind cpm_top cpm_properties #(.N(N)) i_cpm_properties (.core_clk(core_clk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ctr_out(ctr_out));

//--- sim/cpm_pin_src.sv
// external signal sources on the counter source pins
`timescale 1ns/1ps
module cpm_pin_src
  import cpm_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic [NUM_CTR-1:0] run,
  input  wire logic [7:0]         half,
  output logic      [NUM_CTR-1:0] src
);
  int ph = 0;
  // square wave while running; a stopped line falls to its pull-down level
  always @(posedge core_clk) begin
    ph <= (ph + 1 >= half) ? 0 : ph + 1;
    for (int i = 0; i < NUM_CTR; i++) begin
      src[i] <= run[i] & (ph + 1 >= half ? ~src[i] : src[i]);
    end
  end
endmodule

//--- sim/counter_pulse_measure_unit_tb.sv
// self-checking bench for the counter and pulse measurement unit
`timescale 1ns/1ps
module counter_pulse_measure_unit_tb
  import cpm_pkg::*;
;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        s_q = 0;
  logic        s_q1 = 0;
  logic        psel, penable, pwrite, pready, pslverr, er, link;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [4:0]  ctr_gate, gate_r, run, ctr_src, ctr_out;
  logic [7:0]  half;
  logic [31:0] regm [int];
  int          n_errors = 0;
  int          num_checks = 0;
  int          nr = 0;
  int          nf = 0;
  int          ng = 0;

  // lower counter output looped onto the train counter gate for finite trains
  assign ctr_gate = {gate_r[4:2], link ? ctr_out[0] : gate_r[1], gate_r[0]};
  always #50 core_clk = ~core_clk;
  cpm_top i_cpm_top (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctr_src(ctr_src), .ctr_gate(ctr_gate),
    .ctr_out(ctr_out));
  cpm_pin_src i_cpm_pin_src (.core_clk(core_clk), .run(run), .half(half), .src(ctr_src));

  // edge tallies: pin 3 for the event counter, pin 1 only while its gate is high
  always @(posedge core_clk) begin
    s_q <= ctr_src[3];
    s_q1 <= ctr_src[1];
    nr <= nr + int'(ctr_src[3] & ~s_q);
    nf <= nf + int'(~ctr_src[3] & s_q);
    ng <= ng + int'(ctr_src[1] & ~s_q1 & ctr_gate[1]);
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a wait that used up its bound ends the run as a failure
  task automatic bail(input logic bad);
    if (bad) begin
      n_errors++;
      complete_run();
    end
  endtask

  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    bail(pready !== 1'b1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a < 12'h050 && a[3:2] != REG_COUNT) regm[a] = d;
  endtask

  task automatic rc(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd, regm.exists(a) ? regm[a] : 32'h0);
  endtask

  // cycles until the output reaches act, then cycles it stays there
  task automatic pw(input int c, input logic act, output int d, output int w);
    d = 0;
    w = 0;
    while (ctr_out[c] !== act && d < 300) begin
      @(posedge core_clk);
      d++;
    end
    while (ctr_out[c] === act && w < 300) begin
      @(posedge core_clk);
      w++;
    end
    bail(d >= 300 || w >= 300);
  endtask

  initial begin
    int d1, w1, d2, w2, b;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    gate_r = '0;
    run = '0;
    half = 8'h03;
    link = 1'b0;
    void'($urandom(32'h9b6a));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, random contents, read-only count, unmapped places
    for (int a = 0; a < 'h50; a += 4) rc(12'(a));
    rc(OFF_CMD);
    for (int c = 0; c < 5; c++) begin
      wr(12'(c * 16), $urandom & 32'h0000_07f8);
      wr(12'(c * 16 + 4), $urandom & 32'h0000_ffff);
      wr(12'(c * 16 + 8), $urandom & 32'h0000_ffff);
      wr(12'(c * 16 + 12), $urandom);
    end
    for (int a = 0; a < 'h50; a += 4) rc(12'(a));
    apb(1'b1, 12'h0f0, 32'h1);
    chk(32'(er), 32'h1);
    apb(1'b0, 12'h002, 32'h0);
    chk(32'(er), 32'h1);
    $display("test registers done");
    // single pulse, rerun, longer delay, external timebase
    wr(12'h000, 32'h2);
    wr(12'h004, 32'h5);
    wr(12'h008, 32'h3);
    apb(1'b1, OFF_CMD, 32'h1);
    pw(0, 1'b1, d1, w1);
    chk(32'(w1), 32'h3);
    chk(32'(ctr_out[0]), 32'h0);
    apb(1'b1, OFF_CMD, 32'h1);
    pw(0, 1'b1, d2, w2);
    chk(32'(d2 * 16 + w2), 32'(d1 * 16 + 3));
    wr(12'h004, 32'h9);
    apb(1'b1, OFF_CMD, 32'h1);
    pw(0, 1'b1, d2, w2);
    chk(32'(d2 - d1), 32'h4);
    wr(12'h000, 32'ha);
    run[0] <= 1'b1;
    apb(1'b1, OFF_CMD, 32'h1);
    pw(0, 1'b1, d2, w2);
    chk(32'(w2), 32'd18);
    run[0] <= 1'b0;
    // triggered pulse waits for the gate edge
    wr(12'h020, 32'h102);
    wr(12'h024, 32'h2);
    wr(12'h028, 32'h4);
    apb(1'b1, OFF_CMD, 32'h4);
    repeat (20) @(posedge core_clk);
    chk(32'(ctr_out[2]), 32'h0);
    gate_r[2] <= 1'b1;
    pw(2, 1'b1, d2, w2);
    chk(32'(w2), 32'h4);
    $display("test pulse done");
    // continuous train then stop
    wr(12'h010, 32'h3);
    wr(12'h014, 32'h4);
    wr(12'h018, 32'h2);
    apb(1'b1, OFF_CMD, 32'h2);
    pw(1, 1'b1, d2, w2);
    pw(1, 1'b1, d2, w2);
    chk(32'(d2 * 16 + w2), 32'h42);
    apb(1'b1, OFF_CMD, 32'h200);
    b = 0;
    repeat (30) begin
      @(posedge core_clk);
      b += int'(ctr_out[1]);
    end
    chk(32'(b), 32'h0);
    // finite train: 20-cycle gate from counter 0 lets three pulses through
    link <= 1'b1;
    wr(12'h010, 32'h83);
    wr(12'h004, 32'h1);
    wr(12'h008, 32'd20);
    wr(12'h000, 32'h2);
    apb(1'b1, OFF_CMD, 32'h2);
    apb(1'b1, OFF_CMD, 32'h1);
    b = 0;
    d1 = 0;
    repeat (80) begin
      @(posedge core_clk);
      b += int'(ctr_out[1] & ~d1[0]);
      d1 = int'(ctr_out[1]);
    end
    chk(32'(b), 32'h3);
    apb(1'b1, OFF_CMD, 32'h300);
    $display("test train done");
    // event counting on rising then falling edges
    for (int e = 0; e < 2; e++) begin
      wr(12'h030, 32'(e) << 6);
      apb(1'b1, OFF_CMD, 32'h8);
      d1 = e ? nf : nr;
      run[3] <= 1'b1;
      repeat ($urandom_range(80, 20)) @(posedge core_clk);
      run[3] <= 1'b0;
      repeat (6) @(posedge core_clk);
      apb(1'b0, 12'h03c, 32'h0);
      chk(rd, 32'((e ? nf : nr) - d1));
    end
    // frequency: lower counter's single pulse gates the event counter
    wr(12'h010, 32'h80);
    d1 = ng;
    run[1] <= 1'b1;
    apb(1'b1, OFF_CMD, 32'h2);
    apb(1'b1, OFF_CMD, 32'h1);
    repeat (20) @(posedge core_clk);
    b = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      b++;
    end while (rd[1] && b < 20);
    bail(rd[1]);
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd, 32'(ng - d1));
    apb(1'b1, OFF_CMD, 32'h300);
    run[1] <= 1'b0;
    // width armed before the gate pulse; the opening edge is not itself counted
    wr(12'h040, 32'h4);
    apb(1'b1, OFF_CMD, 32'h10);
    gate_r[4] <= 1'b1;
    repeat (37) @(posedge core_clk);
    gate_r[4] <= 1'b0;
    repeat (6) @(posedge core_clk);
    apb(1'b0, 12'h04c, 32'h0);
    chk(rd, 32'd36);
    chk(32'(rd >= 32'(MIN_VALID_CNT)), 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd[19]), 32'h1);
    chk(32'(rd[18]), 32'h0);
    chk(32'(ctr_out), 32'h0);
    $display("test measure done");
    complete_run();
  end
endmodule
